/* hw/fbc_pkg.sv */
/*
 * Package for the flash bus host controller: pin bundles, request types,
 * bus timing counts.
 * Assumes a 100 MHz clock and an asynchronous parallel flash on the pins.
 */
package fbc_pkg;
   localparam int        CLK_PERIOD_NS  = 10;
   // Access times of the faster speed grade; the slower grade needs 90
   localparam int        ADDRESS_ACCESS_TIME_NS       = 70;
   localparam int        T_CE_NS        = 70;
   localparam int        T_SETUP_NS     = 0;
   localparam int        T_WP_NS        = 35;
   localparam int        T_WPH_NS       = 30;
   localparam int        T_RP_NS        = 500;
   localparam int        T_RH_NS        = 50;
   // Least times round up, never under one cycle
   localparam int        ACC_CYC  = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        CE_CYC   = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        RH_CYC   = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int        CNT_W    = 8;
   localparam int        ADDR_W   = 20;
   localparam int        DATA_W   = 16;
   localparam logic [7:0] BYPASS_SEQ_LEN = 8'h02;
   localparam logic [7:0] NORMAL_SEQ_LEN = 8'h04;

   typedef enum logic [1:0] {
      FBC_OP_READ,
      FBC_OP_WRITE,
      FBC_OP_RESTART
   } fbc_op_e;

   // Request from the user side
   typedef struct packed {
      fbc_op_e               op;
      logic                  byteMode;
      logic [ADDR_W-1:0]     addr;
      logic                  addrLow;
      logic [DATA_W-1:0]     data;
   } fbc_req_s;

   // Controls toward the flash pins, all active low, byteSel_n too (low selects byte mode)
   typedef struct packed {
      logic                  chipSel_n;
      logic                  outGate_n;
      logic                  writeStb_n;
      logic                  restart_n;
      logic                  byteSel_n;
      logic [ADDR_W-1:0]     addr;
   } fbc_pins_s;
endpackage : fbc_pkg

/* hw/fbc_host.sv */
/*
 * Host controller that drives an asynchronous parallel flash through its
 * chip-select, output-gate, write-strobe, restart and width pins.
 * Assumes the flash pins are sampled synchronously and the data pins are
 * resolved by the surrounding wiring from dataOe.
 */
`timescale 1ns/1ps
// How it works
// RULE_01: Reads: select and gate low, strobe high.
// RULE_02: Writes: strobe and select low, gate high.
// RULE_03: Command register has no array address.
// RULE_04: Width pin high gives sixteen data pins.
// RULE_05: Width low: eight pins, top pin addresses.
// RULE_06: Twenty-bit word, twenty-one-bit byte address.
// RULE_07: After restart the flash reads array.
// RULE_08: Array mode holds until a command write.
// RULE_09: Restart aborts and returns to array reads.
// RULE_10: Shortcut program needs two writes, not four.
// RULE_11: Erase by sector, sectors or whole chip.
// RULE_12: Sector erase leaves other sectors intact.
// RULE_13: Identification codes read on low byte.
// RULE_14: Status bits read on low byte while busy.
// RULE_15: Suspend holds erase; resume continues it.
// RULE_16: Protected sectors refuse program and erase.
// RULE_17: Low supply blocks writes.
// RULE_18: Select and restart high: standby, floating.
// RULE_19: Wait chip-select access time after standby.
// RULE_20: Deselect does not stop program or erase.
// RULE_21: Stable address enters automatic sleep.
// RULE_22: Sleep keeps last data latched.
// RULE_23: Gate high floats the data pins.
// RULE_24: Restart low floats and ignores accesses.
// RULE_25: Undefined pin mixes float, keep command state.
module fbc_host (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         arst_n,
   // User request
   input  wire logic                         reqValid,
   output logic                              reqReady,
   input  wire fbc_pkg::fbc_req_s            req,
   input  wire logic                         bypassMode,
   // User answer
   output logic                              rspValid,
   output logic [fbc_pkg::DATA_W-1:0]        rspData,
   output logic                              busy,
   // Flash pins
   output fbc_pkg::fbc_pins_s                pins,
   output logic [fbc_pkg::DATA_W-1:0]        dataOut,
   output logic [fbc_pkg::DATA_W-1:0]        dataOe,
   input  wire logic [fbc_pkg::DATA_W-1:0]   dataIn,
   input  wire logic                         opDone
);
   typedef enum logic [2:0] {
      FBC_IDLE,
      FBC_RD,
      FBC_WR,
      FBC_WR_HOLD,
      FBC_RST,
      FBC_RST_HOLD
   } fbc_state_e;

   fbc_state_e                   state, next_state;
   logic [fbc_pkg::CNT_W-1:0]    cnt, next_cnt;
   logic                         selected, next_selected;
   fbc_pkg::fbc_pins_s           next_pins;
   logic [fbc_pkg::DATA_W-1:0]   next_dataOut, next_dataOe;
   logic                         next_rspValid;
   logic [fbc_pkg::DATA_W-1:0]   next_rspData;
   logic [7:0]                   seqLeft, next_seqLeft;

   function automatic logic [fbc_pkg::CNT_W-1:0] cyc(input int n);
      cyc = fbc_pkg::CNT_W'(n - 1);
   endfunction : cyc

   // Lanes the host drives: low byte on byte-mode writes only, top pin is the extra address
   function automatic logic [fbc_pkg::DATA_W-1:0] laneMask(input logic byteMode,
                                                          input logic wr);
      if (!byteMode) begin
         laneMask = wr ? 16'hFFFF : 16'h0000; // RULE_04
      end else begin
         laneMask = wr ? 16'h80FF : 16'h8000; // RULE_05
      end
   endfunction : laneMask

   assign reqReady = (state == FBC_IDLE);
   assign busy     = !opDone; // RULE_20

   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_selected = selected;
      next_pins     = pins;
      next_dataOut  = dataOut;
      next_dataOe   = dataOe;
      next_rspValid = 1'b0;
      next_rspData  = rspData;
      next_seqLeft  = seqLeft;
      case (state)
         FBC_IDLE: begin
            // Standby between accesses: select and strobe high, data floating
            next_pins.chipSel_n  = 1'b1; // RULE_18
            next_pins.outGate_n  = 1'b1; // RULE_23
            next_pins.writeStb_n = 1'b1;
            next_dataOe          = 16'h0000; // RULE_25
            if (reqValid) begin
               next_pins.byteSel_n = !req.byteMode;
               next_pins.addr      = req.addr; // RULE_06
               next_dataOut        = {req.byteMode ? req.addrLow : req.data[15],
                                      req.data[14:0]};
               case (req.op)
                  fbc_pkg::FBC_OP_READ: begin
                     next_pins.chipSel_n = 1'b0; // RULE_01
                     next_pins.outGate_n = 1'b0; // RULE_01
                     next_dataOe         = laneMask(req.byteMode, 1'b0);
                     // A fresh select from standby needs the full select access time
                     next_cnt   = cyc(selected ? fbc_pkg::ACC_CYC : fbc_pkg::CE_CYC); // RULE_19
                     next_state = FBC_RD;
                  end
                  fbc_pkg::FBC_OP_WRITE: begin
                     next_pins.chipSel_n  = 1'b0; // RULE_02
                     next_pins.writeStb_n = 1'b0; // RULE_02
                     next_dataOe          = laneMask(req.byteMode, 1'b1);
                     next_cnt             = cyc(fbc_pkg::WP_CYC);
                     if (seqLeft == 8'h00 || seqLeft == 8'h01) begin
                        next_seqLeft = bypassMode ? fbc_pkg::BYPASS_SEQ_LEN
                                                  : fbc_pkg::NORMAL_SEQ_LEN; // RULE_10
                     end else begin
                        next_seqLeft = seqLeft - 8'h01;
                     end
                     next_state = FBC_WR;
                  end
                  fbc_pkg::FBC_OP_RESTART: begin
                     next_pins.restart_n = 1'b0; // RULE_09
                     next_cnt            = cyc(fbc_pkg::RP_CYC);
                     next_state          = FBC_RST;
                  end
                  default: begin
                     next_state = FBC_IDLE;
                  end
               endcase
            end
         end
         FBC_RD: begin
            if (cnt == '0) begin
               // Status, identification and array data all use read timing
               next_rspData  = dataIn; // RULE_14
               next_rspValid = 1'b1;   // RULE_13
               next_selected = 1'b1;
               next_state    = FBC_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         FBC_WR: begin
            if (cnt == '0) begin
               // Data latches on the rising strobe
               next_pins.writeStb_n = 1'b1;
               next_pins.chipSel_n  = 1'b1;
               next_cnt             = cyc(fbc_pkg::WPH_CYC);
               next_state           = FBC_WR_HOLD;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         FBC_WR_HOLD: begin
            next_dataOe = 16'h0000;
            if (cnt == '0) begin
               next_rspValid = 1'b1;
               next_state    = FBC_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         FBC_RST: begin
            // Device floats and ignores accesses while restart is low
            next_dataOe         = 16'h0000; // RULE_24
            next_pins.chipSel_n = 1'b1;
            if (cnt == '0) begin
               next_pins.restart_n = 1'b1;
               next_cnt            = cyc(fbc_pkg::RH_CYC);
               next_state          = FBC_RST_HOLD;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         FBC_RST_HOLD: begin
            if (cnt == '0) begin
               // Flash is back in array reads; any command sequence restarts
               next_seqLeft  = 8'h00; // RULE_07
               next_selected = 1'b0;
               next_rspValid = 1'b1;
               next_state    = FBC_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         default: begin
            next_state = FBC_IDLE;
         end
      endcase
      if (state == FBC_IDLE && !(reqValid && req.op == fbc_pkg::FBC_OP_READ)) begin
         next_selected = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state    <= FBC_IDLE;
         cnt      <= '0;
         selected <= 1'b0;
         pins     <= '{chipSel_n: 1'b1, outGate_n: 1'b1, writeStb_n: 1'b1,
                       restart_n: 1'b0, byteSel_n: 1'b0, addr: '0};
         dataOut  <= 16'h0000;
         dataOe   <= 16'h0000;
         rspValid <= 1'b0;
         rspData  <= 16'h0000;
         seqLeft  <= 8'h00;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         selected <= next_selected;
         pins     <= next_pins;
         dataOut  <= next_dataOut;
         dataOe   <= next_dataOe;
         rspValid <= next_rspValid;
         rspData  <= next_rspData;
         seqLeft  <= next_seqLeft;
      end
   end
endmodule : fbc_host

/* tb/fbc_host_assertions.sv */
/* Pin-level checks on the flash host controller.
   Bound to fbc_host from the testbench top; sees only its ports. */
`timescale 1ns/1ps
module fbc_host_assertions (
   // Clock and reset
   input wire logic                       clock,
   input wire logic                       arst_n,
   // Watched outputs
   input wire logic                       rspValid,
   input wire fbc_pkg::fbc_pins_s         pins,
   input wire logic [fbc_pkg::DATA_W-1:0] dataOe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_read_strobe: assert property (!pins.chipSel_n && !pins.outGate_n |-> pins.writeStb_n)
      else $error("read cycle with write strobe low");
   a_read_nodrive: assert property (!pins.outGate_n |->
      dataOe == (pins.byteSel_n ? 16'h0000 : 16'h8000))
      else $error("host drives data while gate is low");
   a_write_gate: assert property (!pins.writeStb_n |-> !pins.chipSel_n && pins.outGate_n)
      else $error("write strobe without select or with gate low");
   a_write_width: assert property ($fell(pins.writeStb_n) |->
      (!pins.writeStb_n)[*4] ##1 pins.writeStb_n)
      else $error("write strobe width wrong");
   a_write_hold: assert property ($rose(pins.writeStb_n) |-> dataOe != '0 ##1 dataOe == '0)
      else $error("write data hold wrong");
   a_access_wait: assert property ($fell(pins.outGate_n) |->
      (!pins.outGate_n && !pins.chipSel_n)[*7] ##1 rspValid)
      else $error("read answered before access time");
endmodule : fbc_host_assertions

/* tb/fbc_flash_model.sv */
/* Behavioural flash on the host pins: small array, byte view, busy time.
   Assumes registered pins from the host; no clock of its own. */
`timescale 1ns/1ps
module fbc_flash_model (
   // Host side pins
   input  wire fbc_pkg::fbc_pins_s         pins,
   input  wire logic [fbc_pkg::DATA_W-1:0] dataOut,
   input  wire logic [fbc_pkg::DATA_W-1:0] dataOe,
   // Resolved data pins and done indicator
   output logic [fbc_pkg::DATA_W-1:0]      dataIn,
   output logic                            opDone
);
   localparam int          PROG_NS     = 300;
   localparam int          ERASE_NS    = 400;
   localparam logic [3:0]  PROT_WORD   = 4'hF;
   // Command keys and codes belong to this model only; values are arbitrary
   localparam logic [15:0] ERASE_KEY   = 16'hE5E5;
   localparam logic [15:0] ID_KEY      = 16'h1D1D;
   localparam logic [7:0]  ID_CODE     = 8'h6B;
   localparam logic [7:0]  STATUS_BUSY = 8'h40;
   logic [15:0] mem [0:15];
   logic [7:0]  bmem [0:15];
   logic [15:0] last;
   logic [15:0] drv;
   logic [15:0] cmdData;
   logic [3:0]  cmdAddr;
   logic        rd;
   logic        bm;
   logic        idMode;
   logic        supplyOk;
   logic [3:0]  bi;
   initial begin
      opDone = 1'b1;
      idMode = 1'b0;
      supplyOk = 1'b1;
      cmdData = 16'h0000;
      cmdAddr = 4'h0;
      last = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'hA000 + 16'(i);
         bmem[i] = 8'h50 + 8'(i);
      end
   end
   assign bm = !pins.byteSel_n;
   assign bi = {pins.addr[2:0], dataOut[15]};
   assign rd = pins.restart_n && !pins.chipSel_n
               && !pins.outGate_n && pins.writeStb_n;
   // Released pins show the inverse of the last value so a stale read cannot match
   always_comb begin
      if (!rd) drv = ~last;
      else if (!opDone) drv = {8'h00, STATUS_BUSY};
      else if (idMode) drv = {8'h00, ID_CODE};
      else if (bm) drv = {~last[15:8], bmem[bi]};
      else drv = mem[pins.addr[3:0]];
   end
   // Sleep keeps the last data read latched while the address rests
   always @* begin
      if (rd) last[7:0] = drv[7:0];
      if (rd && !bm) last[15:8] = drv[15:8];
   end
   assign dataIn = (dataOe & dataOut) | (~dataOe & drv);
   always @(negedge pins.writeStb_n) begin
      #1;
      if (pins.restart_n && !pins.chipSel_n && pins.outGate_n && supplyOk) begin
         // Command latches sit apart from the array
         cmdAddr = pins.addr[3:0];
         cmdData = dataOut;
         if (!bm && cmdData == ID_KEY) begin
            idMode = 1'b1;
         end else if (!bm && cmdData == ERASE_KEY) begin
            // One sector is four words here; other sectors keep their data
            for (int i = 0; i < 16; i++) begin
               if (i[3:2] == cmdAddr[3:2] && i[3:0] != PROT_WORD) begin
                  mem[i] = 16'hFFFF;
               end
            end
            opDone = 1'b0;
            #(ERASE_NS);
            opDone = 1'b1;
         end else if (bm || cmdAddr != PROT_WORD) begin
            if (bm) bmem[bi] = cmdData[7:0];
            else mem[cmdAddr] = cmdData;
            opDone = 1'b0;
            #(PROG_NS);
            opDone = 1'b1;
         end
      end
   end
   always @(negedge pins.restart_n) begin
      opDone = 1'b1;
      idMode = 1'b0;
   end
endmodule : fbc_flash_model

/* tb/fbc_host_tb.sv */
/* Self-checking testbench for fbc_host driving the flash model.
   Assumes the package, design, model and checker are compiled first. */
`timescale 1ns/1ps
module fbc_host_tb;
   logic                       clock = 0;
   logic                       arst_n = 0;
   logic                       reqValid = 0;
   logic                       bypassMode = 0;
   fbc_pkg::fbc_req_s          req = '0;
   logic                       reqReady, rspValid, busy, opDone;
   logic [fbc_pkg::DATA_W-1:0] rspData, dataOut, dataOe, dataIn;
   fbc_pkg::fbc_pins_s         pins;
   int                         err_count = 0;
   int                         check_count = 0;
   int                         cycles = 0;
   int                         n;
   always #5 clock = ~clock;
   fbc_host u_dut (.clock(clock), .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady),
      .req(req), .bypassMode(bypassMode), .rspValid(rspValid), .rspData(rspData), .busy(busy),
      .pins(pins), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .opDone(opDone));
   fbc_flash_model u_flash (.pins(pins), .dataOut(dataOut), .dataOe(dataOe),
      .dataIn(dataIn), .opDone(opDone));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
      end
   endtask : chk_data
   task automatic chk_cnt(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: latency %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt
   // Leaves n at the cycles from the taking edge to the answer
   task automatic do_req(input fbc_pkg::fbc_op_e op, input logic bm, input logic [19:0] a,
         input logic al, input logic [15:0] d);
      @(negedge clock);
      req = '{op, bm, a, al, d};
      reqValid = 1'b1;
      while (reqReady !== 1'b1) @(negedge clock);
      @(negedge clock);
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 300) begin
         @(negedge clock);
         n++;
      end
   endtask : do_req
   task automatic wait_idle();
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(negedge clock);
         n++;
      end
   endtask : wait_idle
   task automatic t_restart();
      do_req(fbc_pkg::FBC_OP_RESTART, 0, 20'h0, 0, 16'h0);
      chk_cnt(n, fbc_pkg::RP_CYC + fbc_pkg::RH_CYC);
      chk_data({15'h0, pins.restart_n}, 16'h0001);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00003, 0, 16'h0);
      chk_cnt(n, fbc_pkg::CE_CYC);
      chk_data(rspData, 16'hA003);
      $display("test restart done");
   endtask : t_restart
   task automatic t_write();
      bypassMode = 1'b1;
      do_req(fbc_pkg::FBC_OP_WRITE, 0, 20'h00005, 0, 16'h1234);
      chk_cnt(n, fbc_pkg::WP_CYC + fbc_pkg::WPH_CYC);
      chk_data({15'h0, busy}, 16'h0001);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00005, 0, 16'h0);
      chk_data({8'h00, rspData[7:0]}, {8'h00, u_flash.STATUS_BUSY});
      wait_idle();
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00005, 0, 16'h0);
      chk_data(rspData, 16'h1234);
      bypassMode = 1'b0;
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00006, 0, 16'h0);
      chk_data(rspData, 16'hA006);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00007, 0, 16'h0);
      chk_data(rspData, 16'hA007);
      $display("test write and reads done");
   endtask : t_write
   task automatic t_byte();
      do_req(fbc_pkg::FBC_OP_WRITE, 1, 20'h00002, 1, 16'h003C);
      wait_idle();
      do_req(fbc_pkg::FBC_OP_READ, 1, 20'h00002, 1, 16'h0);
      chk_data({8'h00, rspData[7:0]}, 16'h003C);
      do_req(fbc_pkg::FBC_OP_READ, 1, 20'h00002, 0, 16'h0);
      chk_data({8'h00, rspData[7:0]}, 16'h0054);
      $display("test byte mode done");
   endtask : t_byte
   task automatic t_modes();
      do_req(fbc_pkg::FBC_OP_WRITE, 0, 20'h00008, 0, u_flash.ERASE_KEY);
      wait_idle();
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00009, 0, 16'h0);
      chk_data(rspData, 16'hFFFF);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00005, 0, 16'h0);
      chk_data(rspData, 16'h1234);
      do_req(fbc_pkg::FBC_OP_WRITE, 0, 20'h0000F, 0, 16'h0BEE);
      chk_data({15'h0, busy}, 16'h0000);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h0000F, 0, 16'h0);
      chk_data(rspData, 16'hA00F);
      u_flash.supplyOk = 1'b0;
      do_req(fbc_pkg::FBC_OP_WRITE, 0, 20'h00006, 0, 16'h0777);
      u_flash.supplyOk = 1'b1;
      chk_data({15'h0, busy}, 16'h0000);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00006, 0, 16'h0);
      chk_data(rspData, 16'hA006);
      do_req(fbc_pkg::FBC_OP_WRITE, 0, 20'h00000, 0, u_flash.ID_KEY);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00000, 0, 16'h0);
      chk_data({8'h00, rspData[7:0]}, {8'h00, u_flash.ID_CODE});
      do_req(fbc_pkg::FBC_OP_RESTART, 0, 20'h0, 0, 16'h0);
      do_req(fbc_pkg::FBC_OP_READ, 0, 20'h00000, 0, 16'h0);
      chk_data(rspData, 16'hA000);
      $display("test erase, protect, supply and identification done");
   endtask : t_modes
   task automatic t_reset();
      @(negedge clock);
      req = '{fbc_pkg::FBC_OP_READ, 1'b0, 20'h00001, 1'b0, 16'h0};
      reqValid = 1'b1;
      @(negedge clock);
      chk_data({15'h0, reqReady}, 16'h0000);
      repeat (2) @(negedge clock);
      reqValid = 1'b0;
      arst_n = 1'b0;
      #1;
      chk_data({14'h0, pins.chipSel_n, pins.restart_n}, 16'h0002);
      repeat (2) @(negedge clock);
      arst_n = 1'b1;
      t_restart();
      $display("test mid-run reset done");
   endtask : t_reset
   initial begin
      repeat (6) @(posedge clock);
      @(negedge clock);
      arst_n = 1'b1;
      t_restart();
      t_write();
      t_byte();
      t_modes();
      t_reset();
      report_and_stop();
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         report_and_stop();
      end
   end
endmodule : fbc_host_tb
bind fbc_host fbc_host_assertions u_chk (.clock(clock), .arst_n(arst_n), .rspValid(rspValid),
   .pins(pins), .dataOe(dataOe));
